// ===== core/rtm_top.v
`timescale 1ns/1ps
`include "rtm_map.vh"
module rtm_top (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  output wire reference_clock_forward_o,
  // SMBus pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output wire sda_oe_o,
  // Straps and EEPROM control
  input wire config_mode_strap_i,
  input wire eeprom_load_n_i,
  input wire eeprom_done_i,
  output reg eeprom_read_o,
  output reg master_mode_o,
  // Shared lock and address strap pins
  input wire [3:0] lock_pin_i,
  output reg [3:0] lock_pin_o,
  output reg [3:0] lock_pin_oe_o,
  // Interrupt pin
  output reg int_n_o,
  output reg int_oe_o,
  // Channel analog status
  input wire [3:0] cdr_locked_i,
  input wire [3:0] signal_detect_i,
  input wire [31:0] horizontal_eye_opening_i,
  input wire [31:0] vertical_eye_opening_i,
  // Channel analog control
  output wire [3:0] vco_preset_o,
  output wire [3:0] coarse_cal_o,
  output wire [3:0] fld_en_o,
  output wire [15:0] div_sel_o
);
  reg strap_done_q;
  reg [3:0] bus_address_straps_q;
  reg mode_strap_q;
  reg [7:0] diag_q, chsel_q;
  reg load_n_q, eeprom_done_q;
  reg [7:0] rdata;
  wire [7:0] addr, wdata;
  wire wr, rd;
  wire [3:0] locked, ch_int;
  wire [31:0] ch_rdata;
  wire ch_space = chsel_q[`RTM_CHSEL_EN_BIT] && addr != `RTM_CH_SELECT;
  wire [1:0] ch = chsel_q[1:0];
  wire [6:0] dev_addr = `RTM_SMB_BASE + {3'b000, bus_address_straps_q};

  // Clock pin passes straight through; a flop cannot forward it
  assign reference_clock_forward_o = ref_clk_i;

  rtm_smb u_smb (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .dev_addr_i(dev_addr),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_o(wr),
    .rd_o(rd),
    .rdata_i(rdata)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
      rtm_chan u_chan (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .sel_i(ch_space && ch == gi),
        .wr_i(wr),
        .rd_i(rd),
        .addr_i(addr),
        .wdata_i(wdata),
        .rdata_o(ch_rdata[gi*8 +: 8]),
        .cdr_locked_i(cdr_locked_i[gi]),
        .signal_detect_i(signal_detect_i[gi]),
        .heo_i(horizontal_eye_opening_i[gi*8 +: 8]),
        .veo_i(vertical_eye_opening_i[gi*8 +: 8]),
        .locked_o(locked[gi]),
        .int_o(ch_int[gi]),
        .vco_preset_o(vco_preset_o[gi]),
        .coarse_cal_o(coarse_cal_o[gi]),
        .fld_en_o(fld_en_o[gi]),
        .div_sel_o(div_sel_o[gi*4 +: 4])
      );
    end
  endgenerate

  // Read data for the byte the bus is about to send
  always @* begin
    if (ch_space) begin
      rdata = ch_rdata[ch*8 +: 8];
    end else begin
      case (addr)
        `RTM_SH_STRAP: begin
          if (diag_q[3:0] == `RTM_DIAG_STRAP_KEY) begin
            rdata = {bus_address_straps_q, 4'h0};
          end else begin
            rdata = 8'h00;
          end
        end
        `RTM_SH_ID: rdata = {`RTM_DEV_REV, `RTM_DEV_ID};
        `RTM_SH_INTCH: rdata = {4'h0, ch_int};
        `RTM_SH_DIAG: rdata = diag_q;
        `RTM_CH_SELECT: rdata = chsel_q;
        default: rdata = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_done_q <= 1'b0;
      bus_address_straps_q <= 4'h0;
      mode_strap_q <= 1'b0;
      diag_q <= `RTM_DIAG_RST;
      chsel_q <= `RTM_CHSEL_RST;
      load_n_q <= 1'b1;
      eeprom_done_q <= 1'b0;
      eeprom_read_o <= 1'b0;
      master_mode_o <= 1'b0;
      lock_pin_o <= 4'h0;
      lock_pin_oe_o <= 4'h0;
      sda_o <= 1'b0;
      int_n_o <= 1'b0;
      int_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      int_n_o <= 1'b0;
      // Straps caught once, first edge after reset release
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        bus_address_straps_q <= lock_pin_i;
        mode_strap_q <= config_mode_strap_i;
        master_mode_o <= ~config_mode_strap_i;
      end
      // Pins only turn to outputs once the straps are held
      lock_pin_oe_o <= {4{strap_done_q}};
      lock_pin_o <= strap_done_q ? locked : 4'h0;
      if (wr && !ch_space && addr == `RTM_SH_DIAG) begin
        diag_q <= wdata;
      end
      if (wr && addr == `RTM_CH_SELECT) begin
        chsel_q <= wdata;
      end
      // Open drain: data is always low, enable only pulls
      int_oe_o <= |ch_int;
      // Load pin falling starts one EEPROM read in master mode;
      // in slave mode the pin is ignored
      load_n_q <= eeprom_load_n_i;
      if (eeprom_read_o && eeprom_done_i) begin
        eeprom_read_o <= 1'b0;
        eeprom_done_q <= 1'b1;
      end else if (strap_done_q && !mode_strap_q && !eeprom_done_q &&
                   load_n_q && !eeprom_load_n_i) begin
        eeprom_read_o <= 1'b1;
      end
    end
  end
endmodule // rtm_top

// ===== core/rtm_map.vh
`ifndef RTM_MAP_VH
`define RTM_MAP_VH
// Shared register offsets
`define RTM_SH_STRAP 8'h00
`define RTM_SH_ID 8'h01
`define RTM_SH_INTCH 8'h05
`define RTM_SH_DIAG 8'h06
`define RTM_CH_SELECT 8'hff
// Channel register offsets
`define RTM_CH_STATUS 8'h01
`define RTM_CH_DIVCFG 8'h2f
`define RTM_CH_EYEST 8'h30
`define RTM_CH_EYETHR 8'h32
`define RTM_CH_REFCFG 8'h36
// Field positions
`define RTM_LOL_BIT 4
`define RTM_LOS_BIT 0
`define RTM_EYE_BIT 4
`define RTM_FLD_BIT 1
`define RTM_EYE_EN_BIT 6
`define RTM_REFMODE_HI 5
`define RTM_REFMODE_LO 4
`define RTM_CHSEL_EN_BIT 2
// Values and reset values
`define RTM_REFMODE_ASSIST 2'b11
`define RTM_DIAG_STRAP_KEY 4'ha
`define RTM_DIVCFG_RST 8'h02
`define RTM_EYETHR_RST 8'h00
`define RTM_REFCFG_RST 8'h30
`define RTM_DIAG_RST 8'h00
`define RTM_CHSEL_RST 8'h00
// Identity, arbitrary neutral values
`define RTM_DEV_REV 4'h1
`define RTM_DEV_ID 4'h5
// SMBus base address, strap value added
`define RTM_SMB_BASE 7'h19
// Timing: reference lock qualification window
`define RTM_CLK_MHZ 50
`define RTM_LOCK_QUAL_NS 2000
`define RTM_LOCK_QUAL_CYC ((`RTM_LOCK_QUAL_NS * `RTM_CLK_MHZ + 999) / 1000)
`endif

// ===== core/rtm_smb.v
`timescale 1ns/1ps
`include "rtm_map.vh"
module rtm_smb (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Bus pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_oe_o,
  // Device address
  input wire [6:0] dev_addr_i,
  // Register access
  output reg [7:0] addr_o,
  output reg [7:0] wdata_o,
  output reg wr_o,
  output reg rd_o,
  input wire [7:0] rdata_i
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACKA = 3'd2;
  localparam ST_WR = 3'd3;
  localparam ST_ACKW = 3'd4;
  localparam ST_RD = 3'd5;
  localparam ST_ACKR = 3'd6;
  reg [2:0] st_q;
  reg scl_q, sda_q, rw_q, ptr_q, nack_q, any_q;
  reg [7:0] sr_q;
  reg [2:0] cnt_q;
  wire rise = scl_i & ~scl_q;
  wire fall = ~scl_i & scl_q;
  wire start = scl_i & scl_q & sda_q & ~sda_i;
  wire stop = scl_i & scl_q & ~sda_q & sda_i;
  always @(posedge ref_clk_i) begin
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (rst_i) begin
      st_q <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe_o <= 1'b0;
      sr_q <= 8'h00;
      cnt_q <= 3'd0;
      rw_q <= 1'b0;
      ptr_q <= 1'b0;
      nack_q <= 1'b0;
      any_q <= 1'b0;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
    end else if (start) begin
      st_q <= ST_ADDR;
      cnt_q <= 3'd0;
      any_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (stop) begin
      st_q <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_WR: begin
          if (rise) begin
            sr_q <= {sr_q[6:0], sda_i};
            cnt_q <= cnt_q + 3'd1;
            any_q <= 1'b1;
          // A start's own clock fall comes before any bit, so it must
          // not be taken for the end of a byte
          end else if (fall && cnt_q == 3'd0 && any_q) begin
            if (st_q == ST_ADDR) begin
              if (sr_q[7:1] == dev_addr_i) begin
                rw_q <= sr_q[0];
                ptr_q <= 1'b1;
                sda_oe_o <= 1'b1;
                st_q <= ST_ACKA;
              end else begin
                st_q <= ST_IDLE;
              end
            end else begin
              // First written byte is the register pointer
              if (ptr_q) begin
                addr_o <= sr_q;
              end else begin
                wdata_o <= sr_q;
                wr_o <= 1'b1;
              end
              ptr_q <= 1'b0;
              sda_oe_o <= 1'b1;
              st_q <= ST_ACKW;
            end
          end
        end
        ST_ACKA, ST_ACKW: begin
          if (fall) begin
            if (st_q == ST_ACKA && rw_q) begin
              // Read strobe lets clear-on-read act once per byte
              sr_q <= {rdata_i[6:0], 1'b0};
              sda_oe_o <= ~rdata_i[7];
              rd_o <= 1'b1;
              cnt_q <= 3'd1;
              st_q <= ST_RD;
            end else begin
              sda_oe_o <= 1'b0;
              cnt_q <= 3'd0;
              any_q <= 1'b0;
              st_q <= ST_WR;
            end
          end
        end
        ST_RD: begin
          if (fall) begin
            if (cnt_q == 3'd0) begin
              sda_oe_o <= 1'b0;
              st_q <= ST_ACKR;
            end else begin
              sda_oe_o <= ~sr_q[7];
              sr_q <= {sr_q[6:0], 1'b0};
              cnt_q <= cnt_q + 3'd1;
            end
          end
        end
        ST_ACKR: begin
          if (rise) begin
            nack_q <= sda_i;
          end else if (fall) begin
            if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              sr_q <= {rdata_i[6:0], 1'b0};
              sda_oe_o <= ~rdata_i[7];
              rd_o <= 1'b1;
              cnt_q <= 3'd1;
              st_q <= ST_RD;
            end
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end
endmodule // rtm_smb

// ===== core/rtm_chan.v
`timescale 1ns/1ps
`include "rtm_map.vh"
module rtm_chan (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Register access
  input wire sel_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // Analog channel status
  input wire cdr_locked_i,
  input wire signal_detect_i,
  input wire [7:0] heo_i,
  input wire [7:0] veo_i,
  // Channel control and status
  output reg locked_o,
  output reg int_o,
  output reg vco_preset_o,
  output reg coarse_cal_o,
  output reg fld_en_o,
  output reg [3:0] div_sel_o
);
  localparam integer QUAL_I = `RTM_LOCK_QUAL_CYC;
  localparam [15:0] QUAL = QUAL_I[15:0];
  reg [7:0] div_q, thr_q, ref_q;
  reg lol_q, los_q, eye_q, sd_q, preset_done_q;
  reg [15:0] qual_q;
  wire ref3 = ref_q[`RTM_REFMODE_HI:`RTM_REFMODE_LO] == `RTM_REFMODE_ASSIST;
  wire wr = sel_i & wr_i;
  wire rd = sel_i & rd_i;
  wire eye_low = heo_i < {thr_q[7:4], 4'h0} | veo_i < {thr_q[3:0], 4'h0};
  wire lock_now = ref3 ? (qual_q == QUAL) : cdr_locked_i;
  always @* begin
    case (addr_i)
      `RTM_CH_STATUS: rdata_o = {3'b000, lol_q, 2'b00, locked_o, los_q};
      `RTM_CH_DIVCFG: rdata_o = div_q;
      `RTM_CH_EYEST: rdata_o = {3'b000, eye_q, 4'h0};
      `RTM_CH_EYETHR: rdata_o = thr_q;
      `RTM_CH_REFCFG: rdata_o = ref_q;
      default: rdata_o = 8'h00;
    endcase
  end
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_q <= `RTM_DIVCFG_RST;
      thr_q <= `RTM_EYETHR_RST;
      ref_q <= `RTM_REFCFG_RST;
      lol_q <= 1'b0;
      los_q <= 1'b0;
      eye_q <= 1'b0;
      sd_q <= 1'b0;
      qual_q <= 16'h0000;
      preset_done_q <= 1'b0;
      locked_o <= 1'b0;
      int_o <= 1'b0;
      vco_preset_o <= 1'b0;
      coarse_cal_o <= 1'b0;
      fld_en_o <= 1'b0;
      div_sel_o <= 4'h0;
    end else begin
      if (wr && addr_i == `RTM_CH_DIVCFG) begin
        div_q <= wdata_i;
      end
      if (wr && addr_i == `RTM_CH_EYETHR) begin
        thr_q <= wdata_i;
      end
      if (wr && addr_i == `RTM_CH_REFCFG) begin
        ref_q <= wdata_i;
      end
      // Reference time window must pass with lock held before it counts
      if (!cdr_locked_i) begin
        qual_q <= 16'h0000;
      end else if (qual_q != QUAL) begin
        qual_q <= qual_q + 16'h0001;
      end
      locked_o <= lock_now;
      sd_q <= signal_detect_i;
      // Set wins over clear-on-read
      if (locked_o && !lock_now) begin
        lol_q <= 1'b1;
      end else if (rd && addr_i == `RTM_CH_STATUS) begin
        lol_q <= 1'b0;
      end
      if (sd_q && !signal_detect_i) begin
        los_q <= 1'b1;
      end else if (rd && addr_i == `RTM_CH_STATUS) begin
        los_q <= 1'b0;
      end
      if (ref_q[`RTM_EYE_EN_BIT] && eye_low) begin
        eye_q <= 1'b1;
      end else if (rd && addr_i == `RTM_CH_EYEST) begin
        eye_q <= 1'b0;
      end
      int_o <= lol_q | los_q | eye_q;
      // One preset per acquisition, rearmed on loss or reconfiguration
      vco_preset_o <= 1'b0;
      if (wr || !cdr_locked_i && locked_o) begin
        preset_done_q <= 1'b0;
      end else if (ref3 && !cdr_locked_i && !preset_done_q) begin
        vco_preset_o <= 1'b1;
        preset_done_q <= 1'b1;
      end
      // Reference drives coarse calibration only; the output clock
      // stays on the channel oscillator
      coarse_cal_o <= ref3 & ~lock_now;
      fld_en_o <= ~div_q[`RTM_FLD_BIT];
      div_sel_o <= div_q[7:4];
    end
  end
endmodule // rtm_chan

// ===== verification/rtm_top_properties.sv
`timescale 1ns/1ps
module rtm_top_properties (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Inputs watched
  input wire eeprom_load_n_i,
  input wire [3:0] cdr_locked_i,
  // Outputs watched
  input wire eeprom_read_o,
  input wire master_mode_o,
  input wire [3:0] lock_pin_o,
  input wire [3:0] lock_pin_oe_o,
  input wire int_n_o,
  input wire int_oe_o,
  input wire [3:0] fld_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_release;
    $fell(rst_i);
  endsequence
  sequence s_unlocked;
    (!cdr_locked_i[0]) [*5];
  endsequence
  sequence s_drop;
    $fell(lock_pin_o[0]);
  endsequence
  chk_strap_then_drive: assert property (
    s_release |-> ##[1:4] (lock_pin_oe_o == 4'hf))
    else $error("lock pins not driving after strap latch");
  chk_fld_reset: assert property (
    s_release |-> (fld_en_o == 4'h0) [*3])
    else $error("false-lock detector on after reset");
  chk_lock_qualify: assert property (
    $rose(lock_pin_o[0]) |-> $past(cdr_locked_i[0], 8))
    else $error("lock shown without held oscillator lock");
  chk_lock_follows: assert property (
    s_unlocked |-> !lock_pin_o[0])
    else $error("lock pin high while unlocked");
  chk_int_on_drop: assert property (
    s_drop |-> ##[0:4] (int_oe_o && !int_n_o))
    else $error("no interrupt after lock loss");
  chk_int_pull_only: assert property (
    int_oe_o |-> !int_n_o)
    else $error("interrupt pin driven high");
  chk_mode_once: assert property (
    lock_pin_oe_o == 4'hf |=> $stable(master_mode_o))
    else $error("configuration mode changed after power-up");
  chk_eeprom_start: assert property (
    master_mode_o && $fell(eeprom_load_n_i) |-> ##[1:3] eeprom_read_o)
    else $error("load request did not start eeprom read");
endmodule // rtm_top_properties

bind rtm_top rtm_top_properties u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .eeprom_load_n_i(eeprom_load_n_i),
  .cdr_locked_i(cdr_locked_i), .eeprom_read_o(eeprom_read_o),
  .master_mode_o(master_mode_o), .lock_pin_o(lock_pin_o),
  .lock_pin_oe_o(lock_pin_oe_o), .int_n_o(int_n_o), .int_oe_o(int_oe_o),
  .fld_en_o(fld_en_o)
);

// ===== verification/rtm_smb_host.sv
`timescale 1ns/1ps
module rtm_smb_host (
  // Clock
  input wire ref_clk_i,
  // Bus lines, sda_o high means released
  input wire sda_i,
  output reg scl_o = 1'b1,
  output reg sda_o = 1'b1,
  // Read results
  output reg rd_valid_o = 1'b0,
  output reg [7:0] rd_data_o = 8'h00
);
  // Clocks per hold (high phase one hold, low phase two); must stay above zero, raise it to run slowly
  integer half = 4;
  task hold;
    repeat (half) @(posedge ref_clk_i);
  endtask
  // Data moves mid low phase so it never looks like start or stop
  task bit_io(input b, output r);
    hold;
    sda_o <= b;
    hold;
    scl_o <= 1'b1;
    hold;
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task byte_io(input [7:0] v, output [7:0] r, output ack);
    integer i;
    reg a;
    for (i = 7; i >= 0; i = i - 1) bit_io(v[i], r[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask
  task start;
    hold;
    sda_o <= 1'b0;
    hold;
    scl_o <= 1'b0;
  endtask
  task stop;
    hold;
    sda_o <= 1'b0;
    hold;
    scl_o <= 1'b1;
    hold;
    sda_o <= 1'b1;
    hold;
  endtask
  // Write: pointer then data; read: pointer, stop, then one byte
  task xfer(input [6:0] a, input [7:0] p, input [7:0] d, input wr,
            output ok);
    reg [7:0] r;
    reg k0, k1, k2, k3;
    start;
    byte_io({a, 1'b0}, r, k0);
    byte_io(p, r, k1);
    if (wr) begin
      byte_io(d, r, k2);
    end else begin
      stop;
      start;
      byte_io({a, 1'b1}, r, k2);
      byte_io(8'hff, r, k3);
      rd_data_o <= r;
      rd_valid_o <= 1'b1;
      @(posedge ref_clk_i);
      rd_valid_o <= 1'b0;
    end
    ok = k0 & k1 & k2;
    stop;
  endtask
endmodule // rtm_smb_host

// ===== verification/rtm_tb.sv
`timescale 1ns/1ps
`include "rtm_map.vh"
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg mode = 1'b1;
  reg load_n = 1'b0;
  reg done = 1'b0;
  reg [3:0] strap = 4'h0;
  reg [3:0] cdr = 4'h0;
  reg [31:0] horizontal_eye_opening = 32'h0000_0000;
  reg [31:0] vertical_eye_opening = 32'h0000_0000;
  reg [3:0] sd = 4'hf;
  reg [3:0] pre = 4'h0;
  wire [3:0] vco, cal;
  wire [15:0] dsel;
  wire scl, hsda, sda_out, sda_oe, fwd, eread, mmode, int_n, int_oe, rd_v;
  wire [3:0] lk_o, lk_oe, fld;
  wire [7:0] rd_d;
  // Pulled-up SDA and interrupt lines: every party only ever pulls low; lock pins are driven by the DUT or the straps
  wire sda_line = hsda & (sda_out | ~sda_oe);
  wire int_line = int_n | ~int_oe;
  wire [3:0] lk_line = (lk_oe & lk_o) | (~lk_oe & strap);
  integer seed = 25;
  integer checked = 0;
  integer n_mismatch = 0;
  integer ch;
  reg ack;
  reg [6:0] dev;
  reg [15:0] exp_q[$];
  rtm_top dut (
    .ref_clk_i(clk), .rst_i(rst), .reference_clock_forward_o(fwd),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .config_mode_strap_i(mode), .eeprom_load_n_i(load_n),
    .eeprom_done_i(done), .eeprom_read_o(eread), .master_mode_o(mmode),
    .lock_pin_i(lk_line), .lock_pin_o(lk_o), .lock_pin_oe_o(lk_oe),
    .int_n_o(int_n), .int_oe_o(int_oe), .cdr_locked_i(cdr),
    .signal_detect_i(sd), .horizontal_eye_opening_i(horizontal_eye_opening),
    .vertical_eye_opening_i(vertical_eye_opening), .vco_preset_o(vco), .coarse_cal_o(cal),
    .fld_en_o(fld), .div_sel_o(dsel)
  );
  rtm_smb_host host (
    .ref_clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(hsda),
    .rd_valid_o(rd_v), .rd_data_o(rd_d)
  );
  always #10 clk = ~clk;
  // Preset pulses last one cycle, so they are kept until looked at
  always @(posedge clk) begin
    if (!rst) pre <= pre | vco;
  end
  task automatic check(input [7:0] seen, input [7:0] expv);
    checked = checked + 1;
    if (seen !== expv) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task final_report;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input [7:0] p, input [7:0] d);
    host.xfer(dev, p, d, 1'b1, ack);
  endtask
  task rd(input [7:0] p, input [7:0] e, input [7:0] m);
    exp_q.push_back({m, e});
    host.xfer(dev, p, 8'h00, 1'b0, ack);
  endtask
  task settle(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Each read byte is matched against the oldest note, masked
  always @(posedge clk) begin
    if (rd_v === 1'b1) begin
      check(rd_d & exp_q[0][15:8], exp_q[0][7:0]);
      exp_q.pop_front();
    end
  end
  initial begin
    strap = 4'($random(seed));
    cdr = 4'($random(seed)) | 4'h1;
    horizontal_eye_opening = $random(seed) & 32'hffff_ff00;
    vertical_eye_opening = $random(seed);
    dev = `RTM_SMB_BASE + {3'b000, strap};
    settle(12);
    rst <= 1'b0;
    settle(4);
    check(8'(lk_oe), 8'h0f);
    check(8'(mmode), 8'h00);
    check(8'(fld), 8'h00);
    check(8'(eread), 8'h00);
    #5 check(8'(fwd), 8'h01);
    // Foreign address must be ignored entirely
    host.xfer(dev ^ 7'h40, `RTM_SH_DIAG, 8'h0a, 1'b1, ack);
    check(8'(ack), 8'h00);
    rd(`RTM_SH_ID, {`RTM_DEV_REV, `RTM_DEV_ID}, 8'hff);
    wr(`RTM_SH_ID, 8'h3c);
    rd(`RTM_SH_ID, {`RTM_DEV_REV, `RTM_DEV_ID}, 8'hff);
    rd(`RTM_SH_STRAP, 8'h00, 8'hf0);
    wr(`RTM_SH_DIAG, 8'h0a);
    rd(`RTM_SH_DIAG, 8'h0a, 8'hff);
    host.half = 7;
    rd(`RTM_SH_STRAP, {strap, 4'h0}, 8'hf0);
    host.half = 4;
    for (ch = 0; ch < 4; ch = ch + 1) begin
      wr(`RTM_CH_SELECT, 8'h04 | 8'(ch));
      rd(`RTM_CH_REFCFG, `RTM_REFCFG_RST, 8'hff);
      rd(`RTM_CH_DIVCFG, `RTM_DIVCFG_RST, 8'hff);
      wr(`RTM_CH_DIVCFG, 8'h60);
      settle(2);
      check(8'(fld), 8'((2 << ch) - 1));
      check(8'(dsel[ch*4 +: 4]), 8'h06);
    end
    check(8'(lk_o), 8'(cdr));
    check(8'({pre[0], cal[0]}), 8'h00);
    cdr[0] <= 1'b0;
    sd[0] <= 1'b0;
    settle(8);
    check(8'(int_line), 8'h00);
    check(8'({pre[0], cal[0]}), 8'h03);
    wr(`RTM_CH_SELECT, 8'h00);
    rd(`RTM_SH_INTCH, 8'h01, 8'h0f);
    wr(`RTM_CH_SELECT, 8'h04);
    rd(`RTM_CH_STATUS, 8'h11, 8'h13);
    rd(`RTM_CH_STATUS, 8'h00, 8'h13);
    settle(4);
    check(8'(int_line), 8'h01);
    wr(`RTM_CH_EYETHR, 8'hff);
    settle(4);
    check(8'(int_line), 8'h01);
    wr(`RTM_CH_REFCFG, 8'h70);
    settle(4);
    check(8'(int_line), 8'h00);
    horizontal_eye_opening[7:0] <= 8'hff;
    vertical_eye_opening[7:0] <= 8'hff;
    rd(`RTM_CH_EYEST, 8'h10, 8'h10);
    rd(`RTM_CH_EYEST, 8'h00, 8'h10);
    settle(4);
    check(8'(int_line), 8'h01);
    rst <= 1'b1;
    mode <= 1'b0;
    load_n <= 1'b1;
    settle(12);
    rst <= 1'b0;
    settle(4);
    check(8'(mmode), 8'h01);
    mode <= 1'b1;
    load_n <= 1'b0;
    settle(3);
    check(8'(eread), 8'h01);
    done <= 1'b1;
    settle(3);
    check(8'(eread), 8'h00);
    check(8'(mmode), 8'h01);
    final_report;
  end
  // About three and a half times the expected run length
  initial begin
    #1_000_000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule // tb
